// ---- core/ssrf_formatter.sv ----
// Operation
// R1: sampler clocked at 100 MHz, 2-bit codes, demuxed 16 ways into 32 bitstreams.
// R2: sampler quantizes to three levels at 1600 Msamp/s in full-bandwidth mode.
// R3: all four channels sampled; selection logic forwards any two of them.
// R4: add one dummy bit after every four data bits, 100 to 125 Mb/s.
// R5: first stage merges padded streams by five into sixteen 625 Mb/s lanes.
// R6: second stage merges sixteen lanes into one 10 Gb/s serial stream.
// R7: far end demultiplexes, strips dummy bits, restores 64 streams at 100 Mb/s.
// R8: correlator takes two 800 MHz channels per antenna at 100 MHz clock.
// R9: dummy bits carry fixed known sync pattern to locate frame and dummy slots.
// R10: stream ordering through both stages is fixed across every link restart.
`timescale 1ns/1ps

module ssrf_fifo #(
  parameter int unsigned WIDTH = 64,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output      logic             inReady,
  // drain side
  output      logic             outValid,
  output      logic [WIDTH-1:0] outData,
  input  wire logic             outReady
);

  // pointers carry one extra wrap bit
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wrPtr;
    logic [AW:0]                 rdPtr;
  } ssrf_fifo_st_t;

  ssrf_fifo_st_t st_r;
  ssrf_fifo_st_t st_nxt;
  logic          fullW;
  logic          emptyW;

  // empty on equal pointers, full when only the wrap bits differ
  assign emptyW   = (st_r.wrPtr == st_r.rdPtr);
  assign fullW    = (st_r.wrPtr[AW-1:0] == st_r.rdPtr[AW-1:0]) &&
                    (st_r.wrPtr[AW] != st_r.rdPtr[AW]);
  assign inReady  = !fullW;
  assign outValid = !emptyW;
  assign outData  = st_r.mem[st_r.rdPtr[AW-1:0]];

  // write and read may fall in the same cycle
  always_comb begin
    st_nxt = st_r;
    if (inValid && !fullW) begin
      st_nxt.mem[st_r.wrPtr[AW-1:0]] = inData;
      st_nxt.wrPtr = st_r.wrPtr + 1'b1;
    end
    if (outReady && !emptyW) begin
      st_nxt.rdPtr = st_r.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

module ssrf_formatter #(
  parameter int unsigned FIFO_DEPTH = ssrf_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  // sampler bitstreams, one bit per stream per word
  input  wire logic [ssrf_pkg::CH_BITS-1:0] sampCh0,
  input  wire logic [ssrf_pkg::CH_BITS-1:0] sampCh1,
  input  wire logic [ssrf_pkg::CH_BITS-1:0] sampCh2,
  input  wire logic [ssrf_pkg::CH_BITS-1:0] sampCh3,
  input  wire logic                         sampValid,
  output      logic                         sampReady,
  // channel selection and link enable, static pins
  input  wire logic [ssrf_pkg::SEL_BITS-1:0] selA,
  input  wire logic [ssrf_pkg::SEL_BITS-1:0] selB,
  input  wire logic                         linkEn,
  // serial link toward the optical transmitter
  output      logic                         serData,
  output      logic                         serValid,
  output      logic                         serFrame
);

  typedef struct packed {
    logic [ssrf_pkg::SEL_BITS-1:0]  selAMeta;
    logic [ssrf_pkg::SEL_BITS-1:0]  selASync;
    logic [ssrf_pkg::SEL_BITS-1:0]  selBMeta;
    logic [ssrf_pkg::SEL_BITS-1:0]  selBSync;
    logic                           enMeta;
    logic                           enSync;
    ssrf_pkg::ssrf_state_t          state;
    logic [2:0]                     slot;
    logic [6:0]                     bitIdx;
    logic                           firstOfFrame;
    logic [ssrf_pkg::SLOT_BITS-1:0] shift;
    logic                           serData;
    logic                           serValid;
    logic                           serFrame;
  } ssrf_st_t;

  ssrf_st_t                       st_r;
  ssrf_st_t                       st_nxt;
  logic [ssrf_pkg::STREAMS-1:0]   pickedW;
  logic [ssrf_pkg::STREAMS-1:0]   fifoDataW;
  logic                           fifoValidW;
  logic                           fifoPopW;

  // pick one of four channel words
  function automatic logic [ssrf_pkg::CH_BITS-1:0] chPick(
    input logic [ssrf_pkg::SEL_BITS-1:0] sel,
    input logic [ssrf_pkg::CH_BITS-1:0]  c0,
    input logic [ssrf_pkg::CH_BITS-1:0]  c1,
    input logic [ssrf_pkg::CH_BITS-1:0]  c2,
    input logic [ssrf_pkg::CH_BITS-1:0]  c3
  );
    logic [ssrf_pkg::CH_BITS-1:0] r;
    case (sel)
      2'h0:    r = c0;
      2'h1:    r = c1;
      2'h2:    r = c2;
      default: r = c3;
    endcase
    return r;
  endfunction

  // map one 64-stream slot onto 80 serial positions: position t carries
  // lane t%16 at lane bit t/16, lane l carries stream 5*l + t/16
  function automatic logic [ssrf_pkg::SLOT_BITS-1:0] slotMap(
    input logic [ssrf_pkg::STREAMS-1:0] v
  );
    logic [ssrf_pkg::SLOT_BITS-1:0] r;
    int unsigned                    lane;
    int unsigned                    sub;
    int unsigned                    strm;
    r = '0;
    for (int unsigned t = 0; t < ssrf_pkg::SLOT_BITS; t++) begin
      lane = t % ssrf_pkg::LANES;
      sub  = t / ssrf_pkg::LANES;
      strm = ssrf_pkg::GROUP * lane + sub;
      r[t] = (strm < ssrf_pkg::STREAMS) ? v[strm] : ssrf_pkg::FILL_BIT;
    end
    return r;
  endfunction

  // two of four channels, A in the low half, B in the high half
  // each code pair holds one three-level sample, passed through untouched
  assign pickedW = {chPick(st_r.selBSync, sampCh0, sampCh1, sampCh2, sampCh3),
                    chPick(st_r.selASync, sampCh0, sampCh1, sampCh2, sampCh3)}; // [R3] [R1] [R2]

  // buffer absorbs the dummy slot, during which nothing is popped

  ssrf_fifo #(
    .WIDTH (ssrf_pkg::STREAMS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst_b    (rst_b),
    .inValid  (sampValid),
    .inData   (pickedW),
    .inReady  (sampReady),
    .outValid (fifoValidW),
    .outData  (fifoDataW),
    .outReady (fifoPopW)
  );

  assign fifoPopW = (st_r.state == ssrf_pkg::SSRF_LOAD) &&
                    (st_r.slot != ssrf_pkg::SLOT_LAST) && fifoValidW;


  // serial outputs straight from flops
  assign serData  = st_r.serData;
  assign serValid = st_r.serValid;
  assign serFrame = st_r.serFrame;

  always_comb begin
    st_nxt          = st_r;
    // two-flop synchronisers on the static pins
    st_nxt.selAMeta = selA;
    st_nxt.selASync = st_r.selAMeta;
    st_nxt.selBMeta = selB;
    st_nxt.selBSync = st_r.selBMeta;
    st_nxt.enMeta   = linkEn;
    st_nxt.enSync   = st_r.enMeta;
    st_nxt.serValid = 1'b0;
    st_nxt.serFrame = 1'b0;
    case (st_r.state)
      ssrf_pkg::SSRF_IDLE: begin
        // every restart begins at slot 0 with the same stream order
        st_nxt.slot   = ssrf_pkg::SLOT_RST; // [R10]
        st_nxt.bitIdx = ssrf_pkg::BIT_RST;
        if (st_r.enSync) begin
          st_nxt.state = ssrf_pkg::SSRF_LOAD;
        end
      end
      ssrf_pkg::SSRF_LOAD: begin
        st_nxt.bitIdx       = ssrf_pkg::BIT_RST;
        st_nxt.firstOfFrame = (st_r.slot == ssrf_pkg::SLOT_RST);
        if (st_r.slot == ssrf_pkg::SLOT_LAST) begin
          // fifth slot: dummy bits of all streams carry the sync word
          st_nxt.shift = slotMap(ssrf_pkg::SYNC_WORD); // [R4] [R9]
          st_nxt.state = ssrf_pkg::SSRF_SHIFT;
        end else if (fifoValidW) begin
          st_nxt.shift = slotMap(fifoDataW); // [R5] [R10]
          st_nxt.state = ssrf_pkg::SSRF_SHIFT;
        end
      end
      ssrf_pkg::SSRF_SHIFT: begin
        st_nxt.serData      = st_r.shift[0]; // [R6]
        st_nxt.serValid     = 1'b1;
        st_nxt.serFrame     = st_r.firstOfFrame && (st_r.bitIdx == ssrf_pkg::BIT_RST);
        st_nxt.shift        = {1'b0, st_r.shift[ssrf_pkg::SLOT_BITS-1:1]};
        st_nxt.bitIdx       = st_r.bitIdx + 7'h1;
        if (st_r.bitIdx == ssrf_pkg::BIT_LAST) begin
          if (st_r.slot == ssrf_pkg::SLOT_LAST) begin
            st_nxt.slot  = ssrf_pkg::SLOT_RST; // [R4]
            // link stops only on a frame boundary
            st_nxt.state = st_r.enSync ? ssrf_pkg::SSRF_LOAD : ssrf_pkg::SSRF_IDLE;
          end else begin
            st_nxt.slot  = st_r.slot + 3'h1;
            st_nxt.state = ssrf_pkg::SSRF_LOAD;
          end
        end
      end
      default: begin
        st_nxt.state = ssrf_pkg::SSRF_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r        <= '0;
      st_r.state  <= ssrf_pkg::SSRF_IDLE;
      st_r.slot   <= ssrf_pkg::SLOT_RST;
      st_r.bitIdx <= ssrf_pkg::BIT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// ---- pkg/ssrf_pkg.sv ----
package ssrf_pkg;

  // sampler side: 16-way demux of 2-bit codes gives 32 bitstreams per channel
  localparam int unsigned CODE_BITS      = 2;
  localparam int unsigned DEMUX_WAYS     = 16;
  localparam int unsigned CH_BITS        = CODE_BITS * DEMUX_WAYS;
  localparam int unsigned NUM_CH         = 4;
  localparam int unsigned SEL_BITS       = 2;
  localparam int unsigned STREAMS        = 2 * CH_BITS;

  // rate up-conversion: one dummy slot after every four data slots
  localparam int unsigned DATA_SLOTS     = 4;
  localparam int unsigned FRAME_SLOTS    = DATA_SLOTS + 1;

  // first stage groups five streams per lane, second stage interleaves lanes
  localparam int unsigned GROUP          = 5;
  localparam int unsigned LANES          = 16;
  localparam int unsigned SLOT_BITS      = GROUP * LANES;

  // sampler clock in MHz, sample rate in Msamp/s, bit rates in Mb/s
  localparam int unsigned SAMPLER_CLK_MHZ = 100;
  localparam int unsigned SAMPLE_RATE_MS  = 1600;
  localparam int unsigned IN_RATE_MBPS    = 100;
  localparam int unsigned PAD_RATE_MBPS   = 125;
  localparam int unsigned LANE_RATE_MBPS  = 625;
  localparam int unsigned SER_RATE_MBPS   = 10000;

  // fixed content of the dummy slot and of the unused filler streams
  localparam logic [STREAMS-1:0] SYNC_WORD = 64'hF0F0_CC33_A55A_0FF1;
  localparam logic               FILL_BIT  = 1'h0;

  // buffer
  localparam int unsigned FIFO_DEPTH     = 32;

  // reset values and last slot and bit indices
  localparam logic [2:0] SLOT_RST        = 3'h0;
  localparam logic [6:0] BIT_RST         = 7'h0;
  localparam logic [6:0] BIT_LAST        = 7'(SLOT_BITS - 1);
  localparam logic [2:0] SLOT_LAST       = 3'(FRAME_SLOTS - 1);

  typedef enum logic [2:0] {
    SSRF_IDLE  = 3'h1,
    SSRF_LOAD  = 3'h2,
    SSRF_SHIFT = 3'h4
  } ssrf_state_t;

endpackage

// ---- verification/ssrf_formatter_props.sv ----
`timescale 1ns/1ps
module ssrf_formatter_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // sampler side
  input wire logic [31:0] sampCh0,
  input wire logic [31:0] sampCh1,
  input wire logic [31:0] sampCh2,
  input wire logic [31:0] sampCh3,
  input wire logic        sampValid,
  input wire logic        sampReady,
  // static pins
  input wire logic [1:0]  selA,
  input wire logic [1:0]  selB,
  input wire logic        linkEn,
  // serial link
  input wire logic        serData,
  input wire logic        serValid,
  input wire logic        serFrame
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [6:0] runLen_r;
  logic [2:0] slotCnt_r;
  logic       valQ_r;
  logic       seen_r;
  int         s;
  logic       expSync;
  function automatic int strm(input logic [6:0] t);
    return 5 * (t % 16) + t / 16;
  endfunction
  assign s = strm(runLen_r);
  assign expSync = s < 64 ? ssrf_pkg::SYNC_WORD[s[5:0]] : 1'b0;
  always_ff @(posedge clk) begin
    valQ_r <= rst_b && serValid;
    runLen_r <= (rst_b && serValid) ? runLen_r + 7'h1 : 7'h0;
    seen_r <= rst_b && (seen_r || serFrame);
    if (!rst_b || serFrame) begin
      slotCnt_r <= 3'h0;
    end else if (valQ_r && !serValid) begin
      slotCnt_r <= slotCnt_r + 3'h1;
    end
  end
  sequence slotEnd;
    serValid ##1 !serValid;
  endsequence
  sequence syncDue;
    slotEnd ##0 (seen_r && slotCnt_r == 3'h3);
  endsequence
  a_slot_len: assert property (slotEnd |-> runLen_r == 7'h50)
    else $error("slot length");
  a_len_bound: assert property (runLen_r <= 7'h50)
    else $error("slot too long");
  a_frame_first: assert property (serFrame |-> serValid && runLen_r == 7'h0)
    else $error("frame mark off");
  a_frame_slots: assert property (serFrame && seen_r |-> slotCnt_r == 3'h5)
    else $error("frame slot count");
  a_sync_bits: assert property (serValid && seen_r && slotCnt_r == 3'h4 |-> serData == expSync)
    else $error("sync bit");
  a_filler_zero: assert property (serValid && s >= 64 |-> !serData)
    else $error("filler bit");
  a_sync_prompt: assert property (syncDue |=> serValid)
    else $error("sync slot late");
  a_ready_reset: assert property ($rose(rst_b) |-> sampReady)
    else $error("not ready after reset");
endmodule

// ---- verification/ssrf_deformatter_model.sv ----
`timescale 1ns/1ps
module ssrf_deformatter_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // serial link
  input  wire logic        serData,
  input  wire logic        serValid,
  input  wire logic        serFrame,
  // recovered word of 64 streams
  output      logic [63:0] word,
  output      logic        wordStb,
  output      logic        isSync
);
  int unsigned t;
  int unsigned slot;
  int unsigned s;
  logic [63:0] acc;
  // fifth slot of a frame is the dummy slot; filler streams dropped
  always @(posedge clk) begin
    wordStb <= 1'b0;
    if (!rst_b) begin
      t = 0;
      slot = 0;
    end else if (serValid === 1'b1) begin
      if (serFrame === 1'b1) slot = 0;
      s = 5 * (t % 16) + t / 16;
      if (s < 64) acc[s] = serData;
      t = t + 1;
      if (t == 80) begin
        word <= acc;
        isSync <= slot == 4;
        wordStb <= 1'b1;
        t = 0;
        slot = slot + 1;
      end
    end
  end
endmodule

// ---- verification/tb_sample_stream_rate_formatter.sv ----
`timescale 1ns/1ps
module tb_sample_stream_rate_formatter;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [31:0] ch [4] = '{default: 32'h0};
  logic        sampValid = 1'b0;
  logic        linkEn = 1'b0;
  logic [1:0]  selA = 2'h0;
  logic [1:0]  selB = 2'h0;
  logic        sampReady;
  logic        serData;
  logic        serValid;
  logic        serFrame;
  logic [63:0] word;
  logic        wordStb;
  logic        isSync;
  int          errors = 0;
  int          compares = 0;
  int          rxData = 0;
  int          rxSync = 0;
  logic [63:0] expQ [$];

  always #50 clk = ~clk;

  ssrf_formatter ssrf_formatter_inst (.clk, .rst_b, .sampCh0(ch[0]), .sampCh1(ch[1]),
    .sampCh2(ch[2]), .sampCh3(ch[3]), .sampValid, .sampReady, .selA, .selB, .linkEn,
    .serData, .serValid, .serFrame);
  ssrf_deformatter_model ssrf_deformatter_model_inst (.clk, .rst_b, .serData, .serValid,
    .serFrame, .word, .wordStb, .isSync);

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] pat(input int c, input int k);
    return {8'(c), 8'hA5, 16'(k)};
  endfunction

  always @(posedge clk) if (wordStb === 1'b1) begin
    if (isSync === 1'b1) begin
      chk("sync", word, ssrf_pkg::SYNC_WORD);
      rxSync++;
    end else begin
      chk("data", word, expQ.size() > 0 ? expQ.pop_front() : 'x);
      rxData++;
    end
  end

  task automatic push(input int k);
    for (int c = 0; c < 4; c++) ch[c] <= pat(c, k);
    sampValid <= 1'b1;
    do @(negedge clk); while (sampReady !== 1'b1);
    @(posedge clk);
    expQ.push_back({pat(selB, k), pat(selA, k)});
  endtask

  task automatic waitRx(input int n);
    repeat (5000) if (rxData < n || rxSync < n / 4) @(posedge clk);
    chk("words", 64'(rxData), 64'(n));
    chk("frames", 64'(rxSync), 64'(n / 4));
  endtask

  task automatic t_fill;
    for (int k = 0; k < 32; k++) push(k);
    @(negedge clk);
    chk("full", 64'(sampReady), 64'h0);
    @(posedge clk);
    sampValid <= 1'b0;
    linkEn <= 1'b1;
    waitRx(32);
  endtask

  task automatic t_select;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      selA <= 2'(i);
      selB <= 2'(i >> 2);
      repeat (3) @(posedge clk);
      for (int k = 0; k < 4; k++) push(100 + 4 * i + k);
      sampValid <= 1'b0;
      waitRx(36 + 4 * i);
    end
  endtask

  task automatic print_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("ready", 64'(sampReady), 64'h1);
    t_fill;
    t_select;
    print_verdict;
  end

  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    print_verdict;
  end
endmodule

bind ssrf_formatter ssrf_formatter_props ssrf_formatter_props_inst (.clk, .rst_b, .sampCh0,
  .sampCh1, .sampCh2, .sampCh3, .sampValid, .sampReady, .selA, .selB, .linkEn, .serData,
  .serValid, .serFrame);
